// file: hw/aasc_map.vh
`ifndef AASC_MAP_VH
`define AASC_MAP_VH
// register byte offsets
`define AASC_CTRL_OFS       8'h00
`define AASC_STATUS_OFS     8'h04
`define AASC_IRQ_STAT_OFS   8'h08
`define AASC_IRQ_MASK_OFS   8'h0c
// ctrl fields
`define AASC_CTRL_AUTO_EN   0
`define AASC_CTRL_RESET     32'h0000_0001
// status fields
`define AASC_ST_AWAKE       0
`define AASC_ST_DRV_EN      1
`define AASC_ST_PRESENT     2
`define AASC_ST_FORCED_OFF  3
`define AASC_ST_FORCED_ON   4
// interrupt event bits
`define AASC_EV_SLEEP       0
`define AASC_EV_WAKE        1
`define AASC_EV_PRESENT     2
`define AASC_EV_WIDTH       3
// timing
`define AASC_CLK_HZ         50000000
`define AASC_IDLE_SEC       30
`define AASC_IDLE_CYC       (`AASC_IDLE_SEC * `AASC_CLK_HZ)
`define AASC_WAKE_NS        25000
`define AASC_CLK_NS         20
`define AASC_WAKE_CYC       ((`AASC_WAKE_NS + `AASC_CLK_NS - 1) / `AASC_CLK_NS)
`endif

// file: hw/aasc_top.v
// The register offsets and register access over AHB-Lite were decided locally.
`timescale 1ns/1ns
`include "aasc_map.vh"

module aasc_top #(
    parameter NUM_TX    = 5,
    parameter NUM_RX    = 3,
    parameter IDLE_CYC  = `AASC_IDLE_CYC,
    parameter WAKE_CYC  = `AASC_WAKE_CYC
) (
    input  wire              hclk,
    input  wire              hresetn,
    input  wire              hsel,
    input  wire [31:0]       haddr,
    input  wire [1:0]        htrans,
    input  wire              hwrite,
    input  wire [2:0]        hsize,
    input  wire [31:0]       hwdata,
    input  wire              hready,
    output reg  [31:0]       hrdata,
    output reg               hreadyout,
    output reg               hresp,
    output reg               irq,
    input  wire              force_awake_in,
    input  wire              force_sleep_n_in,
    input  wire [NUM_TX-1:0] tx_logic_in,
    input  wire [NUM_RX-1:0] rx_line_in,
    input  wire [NUM_RX-1:0] rx_valid_in,
    input  wire              pump_ready_in,
    output reg  [NUM_TX-1:0] tx_line_out,
    output reg  [NUM_TX-1:0] tx_line_oe,
    output reg  [NUM_RX-1:0] rx_logic_out,
    output reg  [NUM_RX-1:0] rx_logic_oe,
    output reg               monitor_receiver_out,
    output reg               signal_present_out,
    output reg               pump_enable_out
);

    // data inputs are the ones whose edges count as activity
    localparam NDATA    = NUM_TX + NUM_RX;
    // data inputs, one valid flag per receiver, both forces and pump ready
    localparam NIN      = NDATA + NUM_RX + 3;
    localparam ST_RUN   = 2'h0;
    localparam ST_SLEEP = 2'h1;
    localparam ST_WAKE  = 2'h2;
    // end points of the two counters, cut to the counter widths on purpose
    localparam [15:0] WAKE_LAST = WAKE_CYC[15:0] - 16'h0001;
    localparam [31:0] IDLE_LAST = IDLE_CYC[31:0] - 32'h0000_0001;

    // every pin input, gathered for the shared synchroniser; the valid flags
    // are synchronised one by one, so an async glitch cannot fake their or
    wire [NIN-1:0] pin_raw;
    wire [NIN-1:0] pin_s;
    assign pin_raw = {pump_ready_in, force_sleep_n_in, force_awake_in,
                      rx_valid_in, rx_line_in, tx_logic_in};

    // two flops per pin before any logic looks at it
    aasc_sync2 #(
        .WIDTH   (NIN)
    ) i_pin_sync (
        .hclk    (hclk),
        .hresetn (hresetn),
        .d_in    (pin_raw),
        .q_out   (pin_s)
    );

    // synchronised fields
    wire [NUM_TX-1:0] tx_s      = pin_s[NUM_TX-1:0];
    wire [NUM_RX-1:0] rx_s      = pin_s[NDATA-1:NUM_TX];
    wire [NUM_RX-1:0] valid_s   = pin_s[NDATA+NUM_RX-1:NDATA];
    wire              f_on_s    = pin_s[NDATA+NUM_RX];
    wire              f_off_n_s = pin_s[NDATA+NUM_RX+1];
    wire              pump_s    = pin_s[NDATA+NUM_RX+2];

    // edge detector after the synchroniser; prime_r masks the cycles in which
    // the stage is still filling, so a pin resting high gives no false wake
    reg  [NDATA-1:0] prev_r;
    reg  [2:0]       prime_r;
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            prev_r  <= {NDATA{1'b0}};
            prime_r <= 3'h0;
        end else begin
            prev_r  <= pin_s[NDATA-1:0];
            prime_r <= {prime_r[1:0], 1'b1};
        end
    end

    // an edge on any transmitter or receiver input counts as activity
    wire primed     = prime_r[2];
    wire activity   = primed && (|(pin_s[NDATA-1:0] ^ prev_r));
    // force decode; force-sleep low wins over everything else
    wire forced_off = !f_off_n_s;
    wire forced_on  = f_off_n_s && f_on_s;
    wire auto_mode  = f_off_n_s && !f_on_s;

    // software registers
    reg                       auto_en_r;
    reg  [`AASC_EV_WIDTH-1:0] ev_stat_r;
    reg  [`AASC_EV_WIDTH-1:0] ev_mask_r;

    // inactivity timer; 32 bits cover the 30 s default at 50 mhz
    reg  [31:0] idle_cnt_r;
    reg  [15:0] wake_cnt_r;
    reg  [1:0]  state_r;
    reg  [1:0]  state_nxt;
    wire        idle_done = (idle_cnt_r >= IDLE_LAST);

    // the count saturates, so a long quiet spell never wraps round;
    // a cleared ctrl enable keeps it at zero, which holds the block awake
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            idle_cnt_r <= 32'h0000_0000;
        end else if (!auto_mode || !auto_en_r || activity) begin
            idle_cnt_r <= 32'h0000_0000;
        end else if (!idle_done) begin
            idle_cnt_r <= idle_cnt_r + 32'h0000_0001;
        end
    end

    // power state: run, asleep, or waking up while pumps recover
    // a forced-on request from sleep still passes the wake delay, since the
    // pump rails need the same recovery time whatever woke the block
    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_RUN: begin
                if (forced_off)
                    state_nxt = ST_SLEEP;
                else if (auto_mode && auto_en_r && idle_done)
                    state_nxt = ST_SLEEP;
            end
            ST_SLEEP: begin
                if (forced_on)
                    state_nxt = ST_WAKE;
                else if (auto_mode && (activity || !auto_en_r))
                    state_nxt = ST_WAKE;
            end
            ST_WAKE: begin
                if (forced_off)
                    state_nxt = ST_SLEEP;
                else if (wake_cnt_r >= WAKE_LAST && pump_s)
                    state_nxt = ST_RUN;
            end
            default: state_nxt = ST_SLEEP;
        endcase
    end

    // state register; the wake counter only runs in the wake state
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_r    <= ST_SLEEP;
            wake_cnt_r <= 16'h0000;
        end else begin
            state_r <= state_nxt;
            if (state_r != ST_WAKE)
                wake_cnt_r <= 16'h0000;
            else if (wake_cnt_r < WAKE_LAST)
                wake_cnt_r <= wake_cnt_r + 16'h0001;
        end
    end

    // running is the only state with live transmitter drivers; the wake state keeps
    // them floating until the pump rail is ready
    wire run = (state_r == ST_RUN);

    // transmitters: data follows always, the enable only while running,
    // so the first driven level after wake is already the right one
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_line_out <= {NUM_TX{1'b0}};
            tx_line_oe  <= {NUM_TX{1'b0}};
        end else begin
            tx_line_out <= ~tx_s;
            tx_line_oe  <= {NUM_TX{run}};
        end
    end

    // receivers float only when forced off; the monitor copy never floats,
    // so ring activity stays visible while the host sleeps
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_logic_out         <= {NUM_RX{1'b0}};
            rx_logic_oe          <= {NUM_RX{1'b0}};
            monitor_receiver_out <= 1'b0;
        end else begin
            rx_logic_out         <= ~rx_s;
            rx_logic_oe          <= {NUM_RX{!forced_off}};
            monitor_receiver_out <= rx_s[0];
        end
    end

    // signal present and pump enable; the detector runs in every mode
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            signal_present_out <= 1'b0;
            pump_enable_out    <= 1'b0;
        end else begin
            signal_present_out <= |valid_s;
            pump_enable_out    <= (state_r != ST_SLEEP);
        end
    end

    // ahb-lite slave: zero wait states, always okay; hsize is not decoded
    // since every register is a whole aligned word
    reg        dp_wr_r;
    reg  [7:0] dp_addr_r;
    wire       take = hsel && hready && htrans[1];

    // address phase capture; only writes need the address carried over,
    // reads are answered straight from the address phase
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_wr_r   <= 1'b0;
            dp_addr_r <= 8'h00;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            dp_wr_r   <= take && hwrite;
            if (take)
                dp_addr_r <= haddr[7:0];
        end
    end

    // register writes land in the data phase, when hwdata stands;
    // writes to unmapped or read-only offsets are dropped
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            auto_en_r <= 1'b1;
            ev_mask_r <= {`AASC_EV_WIDTH{1'b0}};
        end else begin
            if (dp_wr_r && dp_addr_r == `AASC_CTRL_OFS)
                auto_en_r <= hwdata[`AASC_CTRL_AUTO_EN];
            if (dp_wr_r && dp_addr_r == `AASC_IRQ_MASK_OFS)
                ev_mask_r <= hwdata[`AASC_EV_WIDTH-1:0];
        end
    end

    // interrupt events: entered sleep, entered run, signal present rose;
    // each is a one-cycle pulse from comparing with last cycle's value
    reg  [1:0]                prev_state_r;
    reg                       prev_present_r;
    wire [`AASC_EV_WIDTH-1:0] ev_now;
    wire [`AASC_EV_WIDTH-1:0] w1c;
    wire [`AASC_EV_WIDTH-1:0] ev_next;
    assign ev_now = {signal_present_out & !prev_present_r,
                     (state_r == ST_RUN) & (prev_state_r != ST_RUN),
                     (state_r == ST_SLEEP) & (prev_state_r != ST_SLEEP)};
    // write-one clear mask, live only in the data phase of a status write
    assign w1c = (dp_wr_r && dp_addr_r == `AASC_IRQ_STAT_OFS)
                 ? hwdata[`AASC_EV_WIDTH-1:0] : {`AASC_EV_WIDTH{1'b0}};
    // set wins over a simultaneous clear, so no event is ever lost
    assign ev_next = (ev_stat_r & ~w1c) | ev_now;

    // sticky status and the level interrupt, both from flops
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            prev_state_r   <= ST_SLEEP;
            prev_present_r <= 1'b0;
            ev_stat_r      <= {`AASC_EV_WIDTH{1'b0}};
            irq            <= 1'b0;
        end else begin
            prev_state_r   <= state_r;
            prev_present_r <= signal_present_out;
            ev_stat_r      <= ev_next;
            irq            <= |(ev_next & ev_mask_r);
        end
    end

    // status word: forced on, forced off, present, drivers, running
    wire [31:0] status_word;
    assign status_word = {27'h0, forced_on, forced_off, signal_present_out,
                          tx_line_oe[0], run};

    // read mux, decoded from the address phase so that the data stands
    // in the very next cycle without a wait state
    reg  [31:0] rd_mux;
    always @* begin
        rd_mux = 32'h0000_0000;
        case (haddr[7:0])
            `AASC_CTRL_OFS:     rd_mux = {31'h0, auto_en_r};
            `AASC_STATUS_OFS:   rd_mux = status_word;
            `AASC_IRQ_STAT_OFS: rd_mux = {29'h0, ev_stat_r};
            `AASC_IRQ_MASK_OFS: rd_mux = {29'h0, ev_mask_r};
            default:            rd_mux = 32'h0000_0000;
        endcase
    end

    // read data stands for exactly the data phase, zero otherwise
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            hrdata <= 32'h0000_0000;
        else if (take && !hwrite)
            hrdata <= rd_mux;
        else
            hrdata <= 32'h0000_0000;
    end

endmodule // aasc_top

// two-flop synchroniser for pins from outside the hclk domain;
// the first flop may go metastable, so only the second is read outside,
// at the cost of two cycles of latency on every pin
module aasc_sync2 #(
    parameter WIDTH = 1
) (
    input  wire             hclk,
    input  wire             hresetn,
    input  wire [WIDTH-1:0] d_in,
    output wire [WIDTH-1:0] q_out
);

    reg  [WIDTH-1:0] meta_r;
    reg  [WIDTH-1:0] sync_r;

    // both stages clear in reset, matching the idle pin levels except force_sleep_n_in, which idles high
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            meta_r <= {WIDTH{1'b0}};
            sync_r <= {WIDTH{1'b0}};
        end else begin
            meta_r <= d_in;
            sync_r <= meta_r;
        end
    end

    assign q_out = sync_r;

endmodule // aasc_sync2

// file: testbench/aasc_props.sv
`timescale 1ns/1ns
module aasc_props #(
    parameter WAKE_CYC = 8
) (
    input wire       hclk,
    input wire       hresetn,
    input wire       force_awake_in,
    input wire       force_sleep_n_in,
    input wire       pump_ready_in,
    input wire [4:0] tx_logic_in,
    input wire [2:0] rx_line_in,
    input wire [2:0] rx_valid_in,
    input wire [4:0] tx_line_out,
    input wire [4:0] tx_line_oe,
    input wire [2:0] rx_logic_out,
    input wire [2:0] rx_logic_oe,
    input wire       monitor_receiver_out,
    input wire       signal_present_out,
    input wire       pump_enable_out
);
    reg [7:0] on_cnt_r;
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // pins pass a synchroniser, so only a settled input defines the output
    sequence rx_quiet; $stable(rx_line_in)[*4]; endsequence
    sequence tx_quiet; $stable(tx_logic_in)[*4]; endsequence
    sequence off_held; (!force_sleep_n_in)[*4]; endsequence
    sequence on_held; force_sleep_n_in[*4]; endsequence
    // cycles spent forced on with the pump ready, saturating
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) on_cnt_r <= 8'h00;
        else if (!(force_awake_in && force_sleep_n_in && pump_ready_in)) on_cnt_r <= 8'h00;
        else if (on_cnt_r != 8'hff) on_cnt_r <= on_cnt_r + 8'h01;
    end
    rx_invert_a: assert property (rx_quiet |-> rx_logic_oe == 3'h0 || rx_logic_out == ~rx_line_in)
        else $error("receiver output not inverted");
    monitor_copy_a: assert property (rx_quiet |-> monitor_receiver_out == rx_line_in[0])
        else $error("monitor output wrong");
    present_flag_a: assert property ($stable(rx_valid_in)[*4] |-> signal_present_out == |rx_valid_in)
        else $error("signal present wrong");
    forced_off_a: assert property (off_held |=> tx_line_oe == 5'h00 && rx_logic_oe == 3'h0)
        else $error("outputs driven in forced off");
    rx_active_a: assert property (on_held |=> rx_logic_oe == 3'h7)
        else $error("receivers disabled");
    tx_invert_a: assert property (tx_quiet |-> tx_line_out == ~tx_logic_in)
        else $error("transmitter not inverted");
    wake_delay_a: assert property ($rose(tx_line_oe[0]) |-> $past(pump_enable_out, 8))
        else $error("drivers enabled too soon");
    sleep_float_a: assert property (!pump_enable_out |-> tx_line_oe == 5'h00)
        else $error("drivers on with pump off");
    forced_on_a: assert property (on_cnt_r >= WAKE_CYC + 8 |-> tx_line_oe == 5'h1f)
        else $error("forced on not running");
endmodule // aasc_props
bind aasc_top aasc_props #(.WAKE_CYC(WAKE_CYC)) i_props (.*);

// file: testbench/aasc_far_end.sv
`timescale 1ns/1ns
module aasc_far_end (
    input  wire       hclk,
    input  wire       attached,
    input  wire       talk,
    output reg  [2:0] line,
    output wire [2:0] valid
);
    initial line = 3'h0;
    // valid levels exist only while the cable is plugged in
    assign valid = attached ? 3'h7 : 3'h0;
    // unplugged lines fall to the receiver pull-down; talking keeps them moving
    always @(posedge hclk) begin
        if (!attached) line <= 3'h0;
        else if (talk) line <= line + 3'h1;
    end
endmodule // aasc_far_end

// file: testbench/aasc_tb_top.sv
`timescale 1ns/1ns
module aasc_tb_top;
    reg         hclk = 1'b0;
    reg         hresetn = 1'b0;
    reg         hsel = 1'b0;
    reg  [31:0] haddr = 32'h0;
    reg  [1:0]  htrans = 2'h0;
    reg         hwrite = 1'b0;
    reg  [2:0]  hsize = 3'h2;
    reg  [31:0] hwdata = 32'h0;
    reg         force_awake_in = 1'b0;
    reg         force_sleep_n_in = 1'b1;
    reg  [4:0]  tx_logic_in = 5'h0;
    reg         pump_ready_in = 1'b0;
    reg         attached = 1'b1;
    reg         talk = 1'b0;
    wire [31:0] hrdata;
    wire        hreadyout, hresp, irq, monitor_receiver_out, signal_present_out, pump_enable_out;
    wire [4:0]  tx_line_out, tx_line_oe;
    wire [2:0]  rx_logic_out, rx_logic_oe, rx_line_in, rx_valid_in;
    integer     err_count = 0;
    integer     compares = 0;
    integer     seed = 81;
    integer     i, n;
    reg  [31:0] rd, r;
    always #10 hclk = ~hclk;
    aasc_top #(.IDLE_CYC(200), .WAKE_CYC(8)) i_dut (.hready(hreadyout), .*);
    aasc_far_end i_far (.hclk(hclk), .attached(attached), .talk(talk), .line(rx_line_in),
                        .valid(rx_valid_in));
    // compare and report a single result
    task chk(input string nm, input [31:0] exp, input [31:0] got);
        begin
            compares = compares + 1;
            if (got !== exp) begin
                err_count = err_count + 1;
                $display("[FAIL] %0s exp %h got %h", nm, exp, got);
            end
        end
    endtask
    // one single-word transfer, entered right after a rising edge
    task ahb(input w, input [31:0] a, input [31:0] d);
        begin
            hsel <= 1'b1;
            htrans <= 2'h2;
            hwrite <= w;
            haddr <= a;
            @(posedge hclk);
            while (hreadyout !== 1'b1) @(posedge hclk);
            hsel <= 1'b0;
            htrans <= 2'h0;
            hwdata <= d;
            @(posedge hclk);
            while (hreadyout !== 1'b1) @(posedge hclk);
            rd = hrdata;
        end
    endtask
    // bounded wait for a driver enable pattern
    task wait_oe(input [4:0] v);
        for (n = 0; tx_line_oe !== v && n < 400; n = n + 1) @(posedge hclk);
    endtask
    // let the synchroniser settle, then check every pin path
    task pins;
        begin
            repeat (5) @(posedge hclk);
            chk("tx_line_out", {27'h0, ~tx_logic_in}, tx_line_out);
            chk("rx_logic_out", {29'h0, ~rx_line_in}, rx_logic_out);
            chk("monitor", rx_line_in[0], monitor_receiver_out);
            chk("present", |rx_valid_in, signal_present_out);
        end
    endtask
    task tally_and_finish;
        begin
            if (err_count == 0 && compares > 0)
                $display("*** PASS ***");
            else
                $display("*** FAIL ***");
            $finish;
        end
    endtask
    // a hang costs a mismatch; the whole run is about 800 cycles
    initial begin
        #400000;
        err_count = err_count + 1;
        tally_and_finish;
    end
    // main sequence: bus, forced on, auto sleep and wake, forced off
    initial begin
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        ahb(1'b0, 32'h0, 32'h0);
        chk("ctrl reset", 32'h1, rd);
        ahb(1'b0, 32'h10, 32'h0);
        chk("unmapped", 32'h0, rd);
        ahb(1'b1, 32'hc, 32'h7);
        force_awake_in <= 1'b1;
        repeat (40) @(posedge hclk);
        chk("oe without pump", 32'h0, tx_line_oe);
        pump_ready_in <= 1'b1;
        wait_oe(5'h1f);
        chk("forced on", 32'h1f, tx_line_oe);
        ahb(1'b0, 32'h4, 32'h0);
        chk("status on", 32'h17, rd);
        chk("hresp", 32'h0, hresp);
        chk("hreadyout", 32'h1, hreadyout);
        ahb(1'b0, 32'h8, 32'h0);
        chk("run event", 32'h2, rd & 32'h2);
        chk("irq set", 32'h1, irq);
        ahb(1'b1, 32'h8, 32'h7);
        ahb(1'b0, 32'h8, 32'h0);
        chk("w1c", 32'h0, rd);
        chk("irq clear", 32'h0, irq);
        for (i = 0; i < 6; i = i + 1) begin
            r = $random(seed);
            tx_logic_in <= r[4:0];
            pins;
        end
        force_awake_in <= 1'b0;
        repeat (150) @(posedge hclk);
        tx_logic_in <= ~tx_logic_in;
        repeat (180) @(posedge hclk);
        chk("timer restart", 32'h1f, tx_line_oe);
        wait_oe(5'h00);
        chk("sleep time", 32'h1, n > 10 && n < 40);
        chk("rx on in sleep", 32'h7, rx_logic_oe);
        chk("irq sleep", 32'h1, irq);
        pins;
        talk <= 1'b1;
        @(posedge hclk);
        talk <= 1'b0;
        wait_oe(5'h1f);
        chk("auto wake", 32'h1f, tx_line_oe);
        force_awake_in <= 1'b0;
        force_sleep_n_in <= 1'b0;
        attached <= 1'b0;
        talk <= 1'b1;
        repeat (8) @(posedge hclk);
        chk("off tx oe", 32'h0, tx_line_oe);
        chk("off rx oe", 32'h0, rx_logic_oe);
        chk("off pump", 32'h0, pump_enable_out);
        chk("off present", 32'h0, signal_present_out);
        chk("off monitor", rx_line_in[0], monitor_receiver_out);
        ahb(1'b0, 32'h4, 32'h0);
        chk("status off", 32'h8, rd);
        talk <= 1'b0;
        force_awake_in <= 1'b1;
        force_sleep_n_in <= 1'b1;
        wait_oe(5'h1f);
        chk("forced on again", 32'h1f, tx_line_oe);
        force_awake_in <= 1'b0;
        ahb(1'b1, 32'h0, 32'h0);
        repeat (300) @(posedge hclk);
        chk("auto disabled awake", 32'h1f, tx_line_oe);
        tally_and_finish;
    end
endmodule // aasc_tb_top
